// File: src/tcid_decoder.sv
// invalidation descriptor decoder: checks, decodes and issues descriptors
// assumes a fetch unit offering one descriptor at a time, caches that
// accept orders by valid/ready, and a flush unit answering with a pulse
//
// Functional notes
// - flush write buffer before context invalidation
// - process-space flush needs 256-bit queue
// - type is bits 11:9 and 3:0; 7h
// - type 2h is translation cache flush
// - process-space granularity domain, pasid, global
// - process-space granularity 10b is invalid
// - domain tag bits above width ignored
// - pasid ignored for domain granularity
// - wider invalidation allowed, never narrower
// - 128-bit form must match queue width
// - granularity 01b flushes everything
// - granularity 10b flushes by domain tag
// - page-selective invalid without support
// - page match by kind and mode
// - hint keeps stage-two walk entries
// - translation granularity 00b is invalid
// - drain flags, forced from version 2
// - ignore high address, unused tag/hint
// - address mask selects aligned range
// - mask n clears page bits 12..11+n
`timescale 1ns/1ps
`default_nettype none
module tcid_decoder #(
	parameter int         TAG_WIDTH = 16,
	parameter int         MAX_GUEST = 48,
	parameter int         MAX_MASK  = 18,
	parameter logic [3:0] MAJOR_VER = 4'h1
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rstn,
	// register bus
	input  wire logic [3:0]            avsAddress,
	input  wire logic                  avsRead,
	input  wire logic                  avsWrite,
	input  wire logic [31:0]           avsWritedata,
	input  wire logic [3:0]            avsByteenable,
	output logic      [31:0]           avsReaddata,
	output logic                       avsWaitrequest,
	// descriptor from fetch logic
	input  wire logic                  descValid,
	input  wire logic [255:0]          descData,
	output logic                       descReady,
	// error report to queue error logic
	output logic                       descInvalid,
	// write buffer flush
	output logic                       wbFlushReq,
	input  wire logic                  wbFlushDone,
	// orders to the translation caches
	output logic                       cmdValid,
	output tcid_pkg::tcid_cmd_t        cmdData,
	input  wire logic                  cmdReady,
	// drain obligations until next wait descriptor
	output logic                       drainReads,
	output logic                       drainWrites,
	input  wire logic                  waitDone
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// keep the low n bits of a tag
	function automatic logic [15:0] tagKeep(input int n);
		logic [15:0] m;
		m = '0;
		for (int i = 0; i < 16; i++)
		begin
			m[i] = (i < n);
		end
		return m;
	endfunction

	// page bits kept: below guest width, outside the masked range
	function automatic logic [63:0] addrKeep(input logic [5:0] am,
		input int guest);
		logic [63:0] m;
		m = '0;
		for (int i = 0; i < 64; i++)
		begin
			m[i] = (i >= tcid_pkg::PAGE_SHIFT) && (i < guest)
				&& (i >= tcid_pkg::PAGE_SHIFT + int'(am));
		end
		return m;
	endfunction

	localparam logic [15:0] TAG_KEEP = tagKeep(TAG_WIDTH);

	typedef enum logic [1:0] {ST_IDLE, ST_FLUSH, ST_ISSUE} tcid_state_t;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	tcid_pkg::tcid_ctrl_t ctrl_q;
	tcid_state_t          state_q;
	tcid_pkg::tcid_cmd_t  cmd_q;
	logic                 errSticky_q;
	logic                 invalid_q;
	logic                 rdDrain_q;
	logic                 wrDrain_q;
	logic                 pendRd_q;
	logic                 pendWr_q;
	logic [6:0]           lastType_q;
	logic [15:0]          doneCnt_q;
	logic [15:0]          errCnt_q;
	logic                 resp_q;
	logic [31:0]          rdata_q;

	// ----------------------------------------------------------------
	// decode, purely combinational on the offered descriptor
	// ----------------------------------------------------------------
	logic [6:0]          decType;
	logic [1:0]          gran;
	logic                upperZero;
	logic                bad;
	tcid_pkg::tcid_cmd_t cmdD;
	logic                wantRd;
	logic                wantWr;
	logic [5:0]          am;
	logic [63:0]         rawAddr;
	logic [15:0]         tag;

	always_comb
	begin
		decType = {descData[tcid_pkg::TYPE_HI_HI:tcid_pkg::TYPE_HI_LO],
			descData[tcid_pkg::TYPE_LO_HI:tcid_pkg::TYPE_LO_LO]};
		gran      = descData[tcid_pkg::GRAN_HI:tcid_pkg::GRAN_LO];
		upperZero = (descData[tcid_pkg::DESC_W-1:tcid_pkg::HALF_W] == '0);
		am        = descData[tcid_pkg::MASK_HI:tcid_pkg::MASK_LO];
		rawAddr   = {descData[tcid_pkg::ADDR_HI:tcid_pkg::ADDR_LO],
			{tcid_pkg::PAGE_SHIFT{1'b0}}};
		tag = descData[tcid_pkg::TAG_HI:tcid_pkg::TAG_LO] & TAG_KEEP;
		bad    = 1'b0;
		wantRd = 1'b0;
		wantWr = 1'b0;
		cmdD              = '0;
		cmdD.domainTag    = tag;
		cmdD.legacy       = (ctrl_q.tableMode == tcid_pkg::TTM_LEGACY);
		unique case (decType)
			tcid_pkg::TYPE_CTX:
			begin
				// 128-bit form: upper half only zero padding
				bad = ctrl_q.wide256 && !upperZero;
				cmdD.sourceId = descData[tcid_pkg::SID_HI:tcid_pkg::SID_LO];
				cmdD.fnMask   = descData[tcid_pkg::FM_HI:tcid_pkg::FM_LO];
				unique case (gran)
					tcid_pkg::CTX_GLOBAL:
						cmdD.op = tcid_pkg::OP_CTX_ALL;
					tcid_pkg::CTX_DOMAIN:
						// context entries carry no tag in scalable mode
						cmdD.op = (ctrl_q.tableMode == tcid_pkg::TTM_SCALED)
							? tcid_pkg::OP_CTX_ALL : tcid_pkg::OP_CTX_DOM;
					tcid_pkg::CTX_DEVICE:
						cmdD.op = tcid_pkg::OP_CTX_DEV;
					default:
						bad = 1'b1;
				endcase
				if (ctrl_q.tableMode == tcid_pkg::TTM_SCALED)
				begin
					cmdD.domainTag = '0;
				end
			end
			tcid_pkg::TYPE_PC:
			begin
				bad = !ctrl_q.wide256;
				cmdD.pasid = descData[tcid_pkg::PASID_HI:tcid_pkg::PASID_LO];
				unique case (gran)
					tcid_pkg::PC_DOMAIN:
					begin
						cmdD.op    = tcid_pkg::OP_PC_DOM;
						cmdD.pasid = '0;
					end
					tcid_pkg::PC_PASID:
						cmdD.op = tcid_pkg::OP_PC_PASID;
					tcid_pkg::PC_GLOBAL:
					begin
						cmdD.op        = tcid_pkg::OP_PC_ALL;
						cmdD.domainTag = '0;
						cmdD.pasid     = '0;
					end
					default:
						bad = 1'b1;
				endcase
			end
			tcid_pkg::TYPE_TLB:
			begin
				bad = ctrl_q.wide256 && !upperZero;
				// version 2 and later drain regardless of the flags
				wantRd = descData[tcid_pkg::RD_FLUSH_B]
					|| (MAJOR_VER >= tcid_pkg::VER_ALWAYS_DRAIN);
				wantWr = descData[tcid_pkg::WR_FLUSH_B]
					|| (MAJOR_VER >= tcid_pkg::VER_ALWAYS_DRAIN);
				unique case (gran)
					tcid_pkg::TLB_GLOBAL:
					begin
						cmdD.op        = tcid_pkg::OP_TLB_ALL;
						cmdD.domainTag = '0;
						cmdD.walkSsDrop = 1'b1;
					end
					tcid_pkg::TLB_DOMAIN:
					begin
						cmdD.op         = tcid_pkg::OP_TLB_DOM;
						cmdD.walkSsDrop = 1'b1;
					end
					tcid_pkg::TLB_PAGE:
					begin
						// a mask beyond the advertised maximum is refused
						bad = bad || !ctrl_q.pageSelSupport
							|| (int'(am) > MAX_MASK);
						cmdD.op       = tcid_pkg::OP_TLB_PAGE;
						cmdD.pageMask = am;
						cmdD.pageAddr = rawAddr
							& addrKeep(am, MAX_GUEST);
						cmdD.leafSsByAddr = 1'b1;
						cmdD.leafFsByAddr = cmdD.legacy;
						cmdD.walkSsDrop   =
							!descData[tcid_pkg::HINT_B];
					end
					default:
						bad = 1'b1;
				endcase
			end
			default:
				bad = 1'b1;
		endcase
	end

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	logic take;
	logic issued;
	logic regWr;

	assign descReady = (state_q == ST_IDLE);
	assign take      = descValid && descReady;
	assign issued    = cmdValid && cmdReady;
	assign cmdValid  = (state_q == ST_ISSUE);
	assign cmdData   = cmd_q;
	assign wbFlushReq = (state_q == ST_FLUSH);
	assign descInvalid = invalid_q;
	assign drainReads  = rdDrain_q;
	assign drainWrites = wrDrain_q;

	// state machine: idle, optional flush, issue
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_q <= ST_IDLE;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
					if (take && !bad)
					begin
						// flush must finish before the context order leaves
						state_q <= (decType == tcid_pkg::TYPE_CTX
							&& ctrl_q.flushNeeded) ? ST_FLUSH : ST_ISSUE;
					end
				ST_FLUSH:
					if (wbFlushDone)
					begin
						state_q <= ST_ISSUE;
					end
				ST_ISSUE:
					if (cmdReady)
					begin
						state_q <= ST_IDLE;
					end
			endcase
		end
	end

	// order held stable while offered to the caches
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			cmd_q    <= '0;
			pendRd_q <= 1'b0;
			pendWr_q <= 1'b0;
		end
		else if (take && !bad)
		begin
			cmd_q    <= cmdD;
			pendRd_q <= wantRd;
			pendWr_q <= wantWr;
		end
	end

	// error pulse and sticky flag; a new error beats a clear
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			invalid_q   <= 1'b0;
			errSticky_q <= 1'b0;
		end
		else
		begin
			invalid_q <= take && bad;
			if (take && bad)
			begin
				errSticky_q <= 1'b1;
			end
			else if (regWr && avsAddress == tcid_pkg::OFS_STATUS
				&& avsByteenable[0] && avsWritedata[tcid_pkg::ST_ERR_B])
			begin
				errSticky_q <= 1'b0;
			end
		end
	end

	// drain obligations; a new obligation beats the wait completion
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rdDrain_q <= 1'b0;
			wrDrain_q <= 1'b0;
		end
		else
		begin
			if (issued && pendRd_q)
			begin
				rdDrain_q <= 1'b1;
			end
			else if (waitDone)
			begin
				rdDrain_q <= 1'b0;
			end
			if (issued && pendWr_q)
			begin
				wrDrain_q <= 1'b1;
			end
			else if (waitDone)
			begin
				wrDrain_q <= 1'b0;
			end
		end
	end

	// counters and last type seen, wrap silently
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			doneCnt_q  <= '0;
			errCnt_q   <= '0;
			lastType_q <= '0;
		end
		else
		begin
			if (take)
			begin
				lastType_q <= decType;
			end
			if (issued)
			begin
				doneCnt_q <= doneCnt_q + 16'h0001;
			end
			if (take && bad)
			begin
				errCnt_q <= errCnt_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// register bus: one wait cycle on every access
	// ----------------------------------------------------------------
	logic [31:0] rdMux;

	assign avsWaitrequest = (avsRead || avsWrite) && !resp_q;
	assign regWr          = avsWrite && resp_q;
	assign avsReaddata    = rdata_q;

	always_comb
	begin
		rdMux = '0;
		unique case (avsAddress)
			tcid_pkg::OFS_CTRL:
				rdMux = 32'(ctrl_q);
			tcid_pkg::OFS_CAPS:
				rdMux = (32'(TAG_WIDTH) << tcid_pkg::CAP_TAGW_LO)
					| (32'(MAX_MASK) << tcid_pkg::CAP_MASK_LO)
					| (32'(MAX_GUEST) << tcid_pkg::CAP_MAX_GUEST_WIDTH_LO)
					| (32'(MAJOR_VER) << tcid_pkg::CAP_VER_LO);
			tcid_pkg::OFS_STATUS:
				rdMux = (32'(errSticky_q) << tcid_pkg::ST_ERR_B)
					| (32'(rdDrain_q) << tcid_pkg::ST_RDDR_B)
					| (32'(wrDrain_q) << tcid_pkg::ST_WRDR_B)
					| (32'(state_q != ST_IDLE) << tcid_pkg::ST_BUSY_B)
					| (32'(lastType_q) << tcid_pkg::ST_TYPE_LO);
			tcid_pkg::OFS_COUNT:
				rdMux = {errCnt_q, doneCnt_q};
			default:
				rdMux = '0;
		endcase
	end

	// answer handshake and read data capture
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			resp_q  <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			resp_q <= (avsRead || avsWrite) && !resp_q;
			if (avsRead && !resp_q)
			begin
				rdata_q <= rdMux;
			end
		end
	end

	// control register, only the low byte holds bits
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			ctrl_q <= tcid_pkg::tcid_ctrl_t'(
				tcid_pkg::CTRL_RESET[tcid_pkg::CTRL_W-1:0]);
		end
		else if (regWr && avsAddress == tcid_pkg::OFS_CTRL
			&& avsByteenable[0])
		begin
			ctrl_q <= tcid_pkg::tcid_ctrl_t'(
				avsWritedata[tcid_pkg::CTRL_W-1:0]);
		end
	end
endmodule
`default_nettype wire

// File: src/tcid_pkg.sv
// constants, field layouts and carrier types for the invalidation decoder
// assumes descriptors arrive whole, 256 bits wide, low half first in bits
`default_nettype none
package tcid_pkg;
	// ----------------------------------------------------------------
	// descriptor layout
	// ----------------------------------------------------------------
	localparam int DESC_W      = 256;
	localparam int HALF_W      = 128;
	localparam int TYPE_LO_HI  = 3;
	localparam int TYPE_LO_LO  = 0;
	localparam int TYPE_HI_HI  = 11;
	localparam int TYPE_HI_LO  = 9;
	localparam int GRAN_HI     = 5;
	localparam int GRAN_LO     = 4;
	localparam int WR_FLUSH_B  = 6;
	localparam int RD_FLUSH_B  = 7;
	localparam int TAG_HI      = 31;
	localparam int TAG_LO      = 16;
	localparam int SID_HI      = 47;
	localparam int SID_LO      = 32;
	localparam int FM_HI       = 49;
	localparam int FM_LO       = 48;
	localparam int PASID_HI    = 51;
	localparam int PASID_LO    = 32;
	localparam int MASK_HI     = 69;
	localparam int MASK_LO     = 64;
	localparam int HINT_B      = 70;
	localparam int ADDR_HI     = 127;
	localparam int ADDR_LO     = 76;
	localparam int PAGE_SHIFT  = 12;
	localparam int ADDR_W      = 64;
	// ----------------------------------------------------------------
	// type and granularity codes
	// ----------------------------------------------------------------
	localparam logic [6:0] TYPE_CTX   = 7'h01;
	localparam logic [6:0] TYPE_TLB   = 7'h02;
	localparam logic [6:0] TYPE_PC    = 7'h07;
	localparam logic [1:0] CTX_GLOBAL = 2'h1;
	localparam logic [1:0] CTX_DOMAIN = 2'h2;
	localparam logic [1:0] CTX_DEVICE = 2'h3;
	localparam logic [1:0] PC_DOMAIN  = 2'h0;
	localparam logic [1:0] PC_PASID   = 2'h1;
	localparam logic [1:0] PC_GLOBAL  = 2'h3;
	localparam logic [1:0] TLB_GLOBAL = 2'h1;
	localparam logic [1:0] TLB_DOMAIN = 2'h2;
	localparam logic [1:0] TLB_PAGE   = 2'h3;
	localparam logic [1:0] TTM_LEGACY = 2'h0;
	localparam logic [1:0] TTM_SCALED = 2'h1;
	localparam logic [3:0] VER_ALWAYS_DRAIN = 4'h2;
	// ----------------------------------------------------------------
	// register map, byte offsets, fields, reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  OFS_CTRL   = 4'h0;
	localparam logic [3:0]  OFS_CAPS   = 4'h4;
	localparam logic [3:0]  OFS_STATUS = 4'h8;
	localparam logic [3:0]  OFS_COUNT  = 4'hC;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTRL_W       = 5;
	localparam int CAP_TAGW_LO  = 0;
	localparam int CAP_MASK_LO  = 8;
	localparam int CAP_MAX_GUEST_WIDTH_LO  = 16;
	localparam int CAP_VER_LO   = 24;
	localparam int ST_ERR_B     = 0;
	localparam int ST_RDDR_B    = 1;
	localparam int ST_WRDR_B    = 2;
	localparam int ST_BUSY_B    = 3;
	localparam int ST_TYPE_LO   = 4;
	localparam int CNT_ERR_LO   = 16;

	typedef enum logic [3:0] {
		OP_CTX_ALL, OP_CTX_DOM, OP_CTX_DEV,
		OP_PC_DOM, OP_PC_PASID, OP_PC_ALL,
		OP_TLB_ALL, OP_TLB_DOM, OP_TLB_PAGE
	} tcid_op_t;

	// control register as software writes it
	typedef struct packed {
		logic       pageSelSupport;   // selective_page_support
		logic       flushNeeded;      // write_buffer_flush_needed
		logic [1:0] tableMode;        // table_mode_field
		logic       wide256;          // queue holds 256-bit descriptors
	} tcid_ctrl_t;

	// one invalidation order for the translation caches
	typedef struct packed {
		tcid_op_t          op;
		logic [15:0]       domainTag;
		logic [19:0]       pasid;
		logic [15:0]       sourceId;
		logic [1:0]        fnMask;
		logic [ADDR_W-1:0] pageAddr;     // masked, page aligned
		logic [5:0]        pageMask;     // page_range_mask
		logic              leafSsByAddr; // stage-two/pass-through leaves
		logic              leafFsByAddr; // stage-one/nested leaves
		logic              walkSsDrop;   // drop stage-two walk entries
		logic              legacy;
	} tcid_cmd_t;
endpackage
`default_nettype wire

// File: testbench/tcid_checker_assertions.sv
// port checker for the invalidation decoder
// assumes binding onto tcid_decoder with the same MAX_GUEST value
`timescale 1ns/1ps
`default_nettype none
module tcid_checker #(
	parameter int MAX_GUEST = 48
) (
	// clock and reset
	input wire logic                clk,
	input wire logic                rstn,
	// register writes
	input wire logic [3:0]          avsAddress,
	input wire logic                avsWrite,
	input wire logic [31:0]         avsWritedata,
	input wire logic                avsWaitrequest,
	// descriptor side
	input wire logic                descValid,
	input wire logic [255:0]        descData,
	input wire logic                descReady,
	input wire logic                descInvalid,
	// flush and cache side
	input wire logic                wbFlushReq,
	input wire logic                wbFlushDone,
	input wire logic                cmdValid,
	input wire tcid_pkg::tcid_cmd_t cmdData
);
	// ----
	// helper logic
	// ----
	logic       wide_q;
	logic       sel_q;
	logic       flush_q;
	logic       take;
	logic [6:0] kind;
	logic [1:0] gran;
	assign take = descValid && descReady;
	assign kind = {descData[11:9], descData[3:0]};
	assign gran = descData[5:4];
	// mirror of the control lanes that decide validity and the write buffer flush
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wide_q  <= 1'h0;
			sel_q   <= 1'h0;
			flush_q <= 1'h0;
		end
		else if (avsWrite && !avsWaitrequest && avsAddress == 4'h0)
		begin
			wide_q  <= avsWritedata[0];
			sel_q   <= avsWritedata[4];
			flush_q <= avsWritedata[3];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ----
	// assertions
	// ----
	AST_FLUSH_FIRST: assert property (
		$rose(cmdValid) && flush_q
		&& cmdData.op inside {tcid_pkg::OP_CTX_ALL,
		tcid_pkg::OP_CTX_DOM, tcid_pkg::OP_CTX_DEV}
		|-> $past(wbFlushReq))
		else $error("context order issued without write buffer flush");
	AST_FLUSH_HOLD: assert property (
		wbFlushReq && !wbFlushDone |=> wbFlushReq)
		else $error("flush request dropped early");
	AST_PC_NARROW: assert property (
		take && kind == tcid_pkg::TYPE_PC && !wide_q |=> descInvalid)
		else $error("process flush in narrow queue accepted");
	AST_PC_RSVD: assert property (
		take && kind == tcid_pkg::TYPE_PC && gran == 2'h2 |=> descInvalid)
		else $error("reserved process granularity accepted");
	AST_TLB_RSVD: assert property (
		take && kind == tcid_pkg::TYPE_TLB && gran == 2'h0 |=> descInvalid)
		else $error("reserved translation granularity accepted");
	AST_PAGE_UNSUP: assert property (
		take && kind == tcid_pkg::TYPE_TLB && gran == 2'h3 && !sel_q
		|=> descInvalid)
		else $error("page flush accepted without support");
	AST_WIDTH_MISMATCH: assert property (
		take && kind == tcid_pkg::TYPE_TLB && wide_q
		&& descData[255:128] != 128'h0 |=> descInvalid)
		else $error("translation flush with wrong form accepted");
	AST_TLB_ALL: assert property (
		take && kind == tcid_pkg::TYPE_TLB && gran == 2'h1 && wide_q
		&& descData[255:128] == 128'h0
		|=> cmdValid && cmdData.op == tcid_pkg::OP_TLB_ALL)
		else $error("global translation flush not issued");
	AST_INV_QUIET: assert property (
		descInvalid |-> !cmdValid && !wbFlushReq)
		else $error("invalid descriptor reached the caches");
	AST_PAGE_ADDR: assert property (
		cmdValid && cmdData.op == tcid_pkg::OP_TLB_PAGE
		|-> (cmdData.pageAddr & ((64'h1 << (cmdData.pageMask + 12))
		- 64'h1)) == 64'h0 && (cmdData.pageAddr >> MAX_GUEST) == 64'h0)
		else $error("page address not masked");
endmodule
bind tcid_decoder tcid_checker #(.MAX_GUEST(MAX_GUEST)) tcid_checker_inst (
	.clk(clk), .rstn(rstn), .avsAddress(avsAddress), .avsWrite(avsWrite),
	.avsWritedata(avsWritedata), .avsWaitrequest(avsWaitrequest),
	.descValid(descValid), .descData(descData), .descReady(descReady),
	.descInvalid(descInvalid), .wbFlushReq(wbFlushReq),
	.wbFlushDone(wbFlushDone), .cmdValid(cmdValid), .cmdData(cmdData)
);
`default_nettype wire

// File: testbench/tcid_decoder_bench.sv
// self-checking bench for the invalidation decoder
// assumes the far model on the cache side, bench drives queue and bus
`timescale 1ns/1ps
`default_nettype none
module tcid_decoder_bench;
	logic                clk;
	logic                rstn;
	logic [3:0]          avsAddress;
	logic                avsRead;
	logic                avsWrite;
	logic [31:0]         avsWritedata;
	logic [31:0]         avsReaddata;
	logic                avsWaitrequest;
	logic                descValid;
	logic [255:0]        descData;
	logic                descReady;
	logic                descInvalid;
	logic                wbFlushReq;
	logic                wbFlushDone;
	logic                cmdValid;
	tcid_pkg::tcid_cmd_t cmdData;
	logic                cmdReady;
	logic                drainReads;
	logic                drainWrites;
	logic                waitDone;
	logic                slow;
	int                  nErrors;
	int                  comparisons;
	tcid_pkg::tcid_cmd_t got;
	logic [31:0]         rd;
	tcid_pkg::tcid_op_t  pcOps [4] = '{tcid_pkg::OP_PC_DOM,
		tcid_pkg::OP_PC_PASID, tcid_pkg::OP_PC_DOM, tcid_pkg::OP_PC_ALL};
	tcid_pkg::tcid_op_t  tlbOps [4] = '{tcid_pkg::OP_TLB_ALL,
		tcid_pkg::OP_TLB_ALL, tcid_pkg::OP_TLB_DOM, tcid_pkg::OP_TLB_ALL};
	// narrow tag and guest widths so the ignore rules show
	tcid_decoder #(.TAG_WIDTH(8), .MAX_GUEST(40), .MAX_MASK(18),
		.MAJOR_VER(4'h1)) tcid_decoder_inst (
		.clk(clk), .rstn(rstn), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite),
		.avsWritedata(avsWritedata), .avsByteenable(4'hF),
		.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
		.descValid(descValid), .descData(descData), .descReady(descReady),
		.descInvalid(descInvalid), .wbFlushReq(wbFlushReq),
		.wbFlushDone(wbFlushDone), .cmdValid(cmdValid), .cmdData(cmdData),
		.cmdReady(cmdReady), .drainReads(drainReads),
		.drainWrites(drainWrites), .waitDone(waitDone));
	tcid_far_model tcid_far_model_inst (
		.clk(clk), .rstn(rstn), .slow(slow), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .wbFlushReq(wbFlushReq),
		.wbFlushDone(wbFlushDone));
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// ----
	// tasks
	// ----
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		comparisons++;
		if (seen !== want)
		begin
			nErrors++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen,
				want);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", comparisons, nErrors);
		if (nErrors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hold the request until waitrequest is seen low at an edge
	task automatic waitBus();
		do @(posedge clk); while (avsWaitrequest !== 1'h0);
	endtask
	task automatic busWrite(input logic [3:0] a, input logic [31:0] d);
		avsAddress   <= a;
		avsWritedata <= d;
		avsWrite     <= 1'h1;
		waitBus();
		avsWrite     <= 1'h0;
	endtask
	task automatic busRead(input logic [3:0] a, output logic [31:0] d);
		avsAddress <= a;
		avsRead    <= 1'h1;
		waitBus();
		d = avsReaddata;
		avsRead    <= 1'h0;
		@(posedge clk);
	endtask
	task automatic sendDesc(input logic [255:0] d);
		descData  <= d;
		descValid <= 1'h1;
		do @(posedge clk); while (descReady !== 1'h1);
		descValid <= 1'h0;
	endtask
	task automatic expectInvalid();
		@(negedge clk);
		check({descInvalid, cmdValid}, 2'h2);
		@(posedge clk);
	endtask
	// order is captured while it stands, ahead of the accepting edge
	task automatic expectOp(input tcid_pkg::tcid_op_t op);
		do @(negedge clk); while (!(cmdValid === 1'h1 && cmdReady === 1'h1));
		got = cmdData;
		check(got.op, op);
		@(posedge clk);
	endtask
	// fixed tag C35A and process id 12345 in every descriptor
	function automatic logic [255:0] desc(input logic [6:0] t,
		input logic [1:0] g, input logic [1:0] f, input logic [63:0] hi);
		return {128'h0, hi, 32'h0001_2345, 16'hC35A, 4'h0, t[6:4], 1'h0,
			f, g, t[3:0]};
	endfunction
	// ----
	// watchdog and main sequence
	// ----
	initial
	begin
		repeat (5000) @(posedge clk);
		nErrors++;
		conclude();
	end
	initial
	begin
		clk = 1'h0; rstn = 1'h0; avsAddress = 4'h0; avsRead = 1'h0;
		avsWrite = 1'h0; avsWritedata = 32'h0; descValid = 1'h0;
		descData = 256'h0; waitDone = 1'h0; slow = 1'h0;
		nErrors = 0; comparisons = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		busRead(tcid_pkg::OFS_CTRL, rd);
		check(rd, 32'h0);
		busRead(tcid_pkg::OFS_CAPS, rd);
		check(rd, 32'h0128_1208);
		busRead(4'h2, rd);
		check(rd, 32'h0);
		sendDesc(desc(tcid_pkg::TYPE_PC, 2'h3, 2'h0, 64'h0));
		expectInvalid();
		busWrite(tcid_pkg::OFS_CTRL, 32'h03);
		busRead(tcid_pkg::OFS_CTRL, rd);
		check(rd, 32'h03);
		$display("test registers done");
		// every process granularity, each followed by matching scope
		for (int g = 0; g < 4; g++)
		begin
			sendDesc(desc(tcid_pkg::TYPE_PC, g[1:0], 2'h0, 64'h0));
			if (g == 2)
				expectInvalid();
			else
			begin
				expectOp(pcOps[g]);
				if (g < 2)
					check(got.domainTag, 16'h005A);
				if (g == 1)
					check(got.pasid, 20'h12345);
			end
			sendDesc(desc(tcid_pkg::TYPE_TLB, (g == 3) ? 2'h1 : 2'h2,
				2'h0, 64'h0));
			expectOp(tlbOps[(g == 3) ? 1 : 2]);
		end
		busRead(tcid_pkg::OFS_STATUS, rd);
		check(rd[0], 1'h1);
		busWrite(tcid_pkg::OFS_STATUS, 32'h1);
		busRead(tcid_pkg::OFS_STATUS, rd);
		check(rd[0], 1'h0);
		$display("test process flush done");
		// translation granularities with slow caches, page unsupported
		slow <= 1'h1;
		for (int g = 0; g < 4; g++)
		begin
			sendDesc(desc(tcid_pkg::TYPE_TLB, g[1:0], 2'h0, 64'h0));
			if (g == 0 || g == 3)
				expectInvalid();
			else
				expectOp(tlbOps[g]);
			if (g == 2)
				check(got.domainTag, 16'h005A);
		end
		sendDesc(desc(tcid_pkg::TYPE_TLB, 2'h1, 2'h0, 64'h0) | {128'h1,
			128'h0});
		expectInvalid();
		slow <= 1'h0;
		$display("test translation flush done");
		// page flush, scalable mode with hint set, 16 pages
		busWrite(tcid_pkg::OFS_CTRL, 32'h13);
		sendDesc(desc(tcid_pkg::TYPE_TLB, 2'h3, 2'h0,
			{52'hF_FFFF_FFFF_FFFF, 5'h0, 1'h1, 6'h04}));
		expectOp(tcid_pkg::OP_TLB_PAGE);
		check(got.pageAddr, 64'h0000_00FF_FFFF_0000);
		check({got.leafSsByAddr, got.leafFsByAddr, got.walkSsDrop,
			got.legacy}, 4'h8);
		// legacy mode, hint clear, a 2 MiB page
		busWrite(tcid_pkg::OFS_CTRL, 32'h11);
		sendDesc(desc(tcid_pkg::TYPE_TLB, 2'h3, 2'h0,
			{52'hF_FFFF_FFFF_FFFF, 5'h0, 1'h0, 6'h09}));
		expectOp(tcid_pkg::OP_TLB_PAGE);
		check(got.pageAddr, 64'h0000_00FF_FFE0_0000);
		check({got.leafSsByAddr, got.leafFsByAddr, got.walkSsDrop,
			got.legacy}, 4'hF);
		$display("test page flush done");
		// read drain held until the next wait completes
		sendDesc(desc(tcid_pkg::TYPE_TLB, 2'h1, 2'h2, 64'h0));
		expectOp(tcid_pkg::OP_TLB_ALL);
		@(negedge clk);
		check({drainReads, drainWrites}, 2'h2);
		@(posedge clk);
		waitDone <= 1'h1;
		@(posedge clk);
		waitDone <= 1'h0;
		@(negedge clk);
		check({drainReads, drainWrites}, 2'h0);
		@(posedge clk);
		$display("test drain done");
		// context flush waits for the write buffer, then coarser ones
		busWrite(tcid_pkg::OFS_CTRL, 32'h0B);
		sendDesc(desc(tcid_pkg::TYPE_CTX, 2'h1, 2'h0, 64'h0));
		@(negedge clk);
		check({wbFlushReq, cmdValid}, 2'h2);
		expectOp(tcid_pkg::OP_CTX_ALL);
		sendDesc(desc(tcid_pkg::TYPE_PC, 2'h3, 2'h0, 64'h0));
		expectOp(tcid_pkg::OP_PC_ALL);
		sendDesc(desc(tcid_pkg::TYPE_TLB, 2'h1, 2'h0, 64'h0));
		expectOp(tcid_pkg::OP_TLB_ALL);
		$display("test context flush done");
		conclude();
	end
endmodule
`default_nettype wire

// File: testbench/tcid_far_model.sv
// model of the translation caches and the write buffer flush unit
// assumes the decoder holds each order until it is accepted
`timescale 1ns/1ps
`default_nettype none
module tcid_far_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// pacing from the bench
	input  wire logic slow,
	// translation cache orders
	input  wire logic cmdValid,
	output logic      cmdReady,
	// write buffer flush unit
	input  wire logic wbFlushReq,
	output logic      wbFlushDone
);
	logic [1:0] hold_q;
	logic [1:0] flush_q;
	// stall counter: slow caches make the decoder hold its order
	always_ff @(posedge clk)
	begin
		if (!rstn || !cmdValid || cmdReady)
			hold_q <= 2'h0;
		else if (hold_q != 2'h3)
			hold_q <= hold_q + 2'h1;
	end
	assign cmdReady = cmdValid && (!slow || hold_q == 2'h3);
	// flush takes a few cycles, answered by a single pulse
	always_ff @(posedge clk)
	begin
		if (!rstn || !wbFlushReq)
			flush_q <= 2'h0;
		else if (flush_q != 2'h3)
			flush_q <= flush_q + 2'h1;
	end
	assign wbFlushDone = wbFlushReq && flush_q == 2'h2;
endmodule
`default_nettype wire
